// >>> hdl/clock_divider.v
/*
 Divider producing a one-cycle enable every div_count input enables.
 Counts ref_clk edges on which tick_in is high; tick_in may be a one-cycle pulse or held high.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_divider #(
	parameter [3:0] div_count = 4'd12
) (
	input wire ref_clk,
	input wire rst_n,
	input wire tick_in,
	output reg tick_out
);
	reg [3:0] cnt_q;
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				if (cnt_q == div_count - 4'h1) begin
					cnt_q <= 4'h0;
					tick_out <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> hdl/edge_sync.v
/*
 Three-stage synchronizer with a rising-edge pulse output.
 Assumes the input is asynchronous to clk; the first stage feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
	input wire ref_clk,
	input wire rst_n,
	input wire async_in,
	output reg rise_pulse
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			rise_pulse <= 1'b0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// A rise counts once the second stage is high while the third still holds the old low level.
			rise_pulse <= s2_q & ~s3_q;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/timer_reload_counter.v
/*
 Timer with 16-bit or split 8-bit auto-reload, capture mode and register access.
 Assumes an 8-bit register bus with one-cycle write strobe and registered read on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer_reload_map.vh"
module timer_reload_counter (
	input wire ref_clk,
	input wire rst_n,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_we,
	input wire sfr_re,
	output reg [7:0] sfr_rdata,
	input wire high_half_clock_select,
	input wire low_half_clock_select,
	input wire comparator_out,
	input wire slow_osc_in,
	output reg irq_req
);
	// ----------------------------------------
	// Control and data registers
	// ----------------------------------------
	reg high_overflow_flag_q;
	reg low_overflow_flag_q;
	reg low_overflow_irq_enable_q;
	reg capture_mode_enable_q;
	reg split_mode_bit_q;
	reg count_run_bit_q;
	reg [1:0] ext_source_select_q;
	reg [7:0] reload_value_low_q;
	reg [7:0] reload_value_high_q;
	reg [7:0] count_low_byte_q;
	reg [7:0] count_high_byte_q;
	reg [7:0] rdata_d;
	wire [7:0] control_byte;
	wire comp_rise;
	wire slow_rise;
	wire sys_tick12;
	wire slow_tick8;
	wire slow_tick2;
	reg ext_tick;
	reg cap_tick;
	wire low_step;
	wire high_step;
	wire low_wrap;
	wire high_wrap;
	wire hi_carry;
	wire wr_ctrl;
	// ----------------------------------------
	// Source synchronization and dividers
	// ----------------------------------------
	edge_sync u_comp_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.async_in(comparator_out),
		.rise_pulse(comp_rise)
	);
	edge_sync u_slow_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.async_in(slow_osc_in),
		.rise_pulse(slow_rise)
	);
	clock_divider #(.div_count(`SYS_DIV)) u_sys_div (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.tick_in(1'b1),
		.tick_out(sys_tick12)
	);
	// Divide by eight as two stages of four and two to reuse the divider.
	clock_divider #(.div_count({1'b0, `SLOW_DIV})) u_slow_div4 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.tick_in(slow_rise),
		.tick_out(slow_tick2)
	);
	clock_divider #(.div_count(4'd2)) u_slow_div8 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.tick_in(slow_tick2),
		.tick_out(slow_tick8)
	);
	// ----------------------------------------
	// Source selection
	// ----------------------------------------
	always @* begin
		ext_tick = sys_tick12;
		cap_tick = slow_tick8;
		case (ext_source_select_q)
			2'b00: begin
				ext_tick = sys_tick12;
				cap_tick = slow_tick8;
			end
			2'b01: begin
				ext_tick = comp_rise;
				cap_tick = slow_tick8;
			end
			2'b10: begin
				ext_tick = sys_tick12;
				cap_tick = comp_rise;
			end
			2'b11: begin
				ext_tick = slow_tick8;
				cap_tick = comp_rise;
			end
			default: begin
				ext_tick = sys_tick12;
				cap_tick = slow_tick8;
			end
		endcase
	end
	// In split mode both bytes share ext_tick; each byte picks it or the system clock.
	assign low_step = split_mode_bit_q ? (low_half_clock_select | ext_tick)
		: (count_run_bit_q & (low_half_clock_select | ext_tick));
	assign low_wrap = low_step & (count_low_byte_q == 8'hff);
	// In 16-bit mode the high byte advances on the low byte carry.
	assign hi_carry = split_mode_bit_q ? (count_run_bit_q & (high_half_clock_select | ext_tick))
		: low_wrap;
	assign high_step = hi_carry & ~capture_mode_enable_q | hi_carry & split_mode_bit_q;
	assign high_wrap = high_step & (count_high_byte_q == 8'hff);
	assign wr_ctrl = sfr_we & (sfr_addr == `ADDR_CONTROL);
	assign control_byte = {high_overflow_flag_q, low_overflow_flag_q, low_overflow_irq_enable_q,
		capture_mode_enable_q, split_mode_bit_q, count_run_bit_q, ext_source_select_q};
	// ----------------------------------------
	// Counter, reload and flags
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			high_overflow_flag_q <= 1'b0;
			low_overflow_flag_q <= 1'b0;
			low_overflow_irq_enable_q <= 1'b0;
			capture_mode_enable_q <= 1'b0;
			split_mode_bit_q <= 1'b0;
			count_run_bit_q <= 1'b0;
			ext_source_select_q <= 2'b00;
			reload_value_low_q <= `RESET_BYTE;
			reload_value_high_q <= `RESET_BYTE;
			count_low_byte_q <= `RESET_BYTE;
			count_high_byte_q <= `RESET_BYTE;
		end else begin
			if (wr_ctrl) begin
				high_overflow_flag_q <= sfr_wdata[`BIT_HIGH_FLAG];
				low_overflow_flag_q <= sfr_wdata[`BIT_LOW_FLAG];
				low_overflow_irq_enable_q <= sfr_wdata[`BIT_LOW_IRQ_EN];
				capture_mode_enable_q <= sfr_wdata[`BIT_CAPTURE_EN];
				split_mode_bit_q <= sfr_wdata[`BIT_SPLIT];
				count_run_bit_q <= sfr_wdata[`BIT_RUN];
				ext_source_select_q <= sfr_wdata[`BIT_SRC_HI:`BIT_SRC_LO];
			end
			if (sfr_we && sfr_addr == `ADDR_RELOAD_LOW)
				reload_value_low_q <= sfr_wdata;
			if (sfr_we && sfr_addr == `ADDR_RELOAD_HIGH)
				reload_value_high_q <= sfr_wdata;
			// Low byte: software write wins over counting.
			if (sfr_we && sfr_addr == `ADDR_COUNT_LOW)
				count_low_byte_q <= sfr_wdata;
			else if (low_step && !(capture_mode_enable_q && !split_mode_bit_q && 1'b0))
				count_low_byte_q <= low_wrap ? (capture_mode_enable_q && !split_mode_bit_q ? 8'h00
					: reload_value_low_q) : count_low_byte_q + 8'h01;
			if (sfr_we && sfr_addr == `ADDR_COUNT_HIGH)
				count_high_byte_q <= sfr_wdata;
			else if (capture_mode_enable_q && !split_mode_bit_q && low_wrap)
				count_high_byte_q <= count_high_byte_q + 8'h01;
			else if (high_step)
				count_high_byte_q <= high_wrap ? reload_value_high_q : count_high_byte_q + 8'h01;
			// Capture copies the running count into the reload bytes.
			if (capture_mode_enable_q && cap_tick) begin
				reload_value_low_q <= count_low_byte_q;
				reload_value_high_q <= count_high_byte_q;
			end
			// Hardware set wins over a software clear in the same cycle.
			if (high_wrap || (capture_mode_enable_q && cap_tick))
				high_overflow_flag_q <= 1'b1;
			if (low_wrap)
				low_overflow_flag_q <= 1'b1;
		end
	end
	// ----------------------------------------
	// Read data and interrupt request
	// ----------------------------------------
	always @* begin
		case (sfr_addr)
			`ADDR_CONTROL: rdata_d = control_byte;
			`ADDR_RELOAD_LOW: rdata_d = reload_value_low_q;
			`ADDR_RELOAD_HIGH: rdata_d = reload_value_high_q;
			`ADDR_COUNT_LOW: rdata_d = count_low_byte_q;
			`ADDR_COUNT_HIGH: rdata_d = count_high_byte_q;
			default: rdata_d = 8'h00;
		endcase
	end
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
			irq_req <= 1'b0;
		end else begin
			sfr_rdata <= sfr_re ? rdata_d : 8'h00;
			irq_req <= high_overflow_flag_q | (low_overflow_irq_enable_q & low_overflow_flag_q);
		end
	end
endmodule
`default_nettype wire

// >>> hdl/timer_reload_map.vh
/*
 Register addresses, control bit positions, reset values and divider counts for the reload timer.
 Assumes a single system clock and an 8-bit special function register bus.
*/
`ifndef TIMER_RELOAD_MAP_VH
`define TIMER_RELOAD_MAP_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_CONTROL 8'hc8
`define ADDR_RELOAD_LOW 8'hca
`define ADDR_RELOAD_HIGH 8'hcb
`define ADDR_COUNT_LOW 8'hcc
`define ADDR_COUNT_HIGH 8'hcd
// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define BIT_HIGH_FLAG 7
`define BIT_LOW_FLAG 6
`define BIT_LOW_IRQ_EN 5
`define BIT_CAPTURE_EN 4
`define BIT_SPLIT 3
`define BIT_RUN 2
`define BIT_SRC_HI 1
`define BIT_SRC_LO 0
// ----------------------------------------
// Reset values and divider counts
// ----------------------------------------
`define RESET_BYTE 8'h00
`define SYS_DIV 4'd12
`define SLOW_DIV 3'd4
`endif

// >>> test/source_model.sv
/* Comparator and slow oscillator model. Assumes both are asynchronous to ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module source_model (
	input wire logic ref_clk,
	output logic comparator_out,
	output logic slow_osc_in
);
	initial begin
		comparator_out = 1'b0;
		slow_osc_in = 1'b0;
		forever #611 slow_osc_in = ~slow_osc_in;
	end
	// Pulses land mid-cycle so the synchronizer sees truly async edges.
	task pulse(input int n);
		repeat (n) begin
			repeat (5) @(posedge ref_clk);
			#7 comparator_out = 1'b1;
			repeat (5) @(posedge ref_clk);
			#7 comparator_out = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// >>> test/timer_monitor.sv
/* Checker on the timer's register bus and interrupt request. Assumes binding to timer_reload_counter. */
`timescale 1ns/1ps
`default_nettype none
module timer_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_we,
	input wire logic sfr_re,
	input wire logic [7:0] sfr_rdata,
	input wire logic irq_req
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_idle_read_zero: assert property (!$past(sfr_re) |-> sfr_rdata == 8'h00)
		else $error("read data not zero when idle");
	a_unmapped_zero: assert property (sfr_re && !(sfr_addr inside {8'hc8, [8'hca:8'hcd]}) |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_reload_low_rw: assert property (sfr_we && sfr_addr == 8'hca ##2 sfr_re && !sfr_we && sfr_addr == 8'hca
		|=> sfr_rdata == $past(sfr_wdata, 3)) else $error("low reload readback");
	a_reload_high_rw: assert property (sfr_we && sfr_addr == 8'hcb ##2 sfr_re && !sfr_we && sfr_addr == 8'hcb
		|=> sfr_rdata == $past(sfr_wdata, 3)) else $error("high reload readback");
	a_ctrl_bits_rw: assert property (sfr_we && sfr_addr == 8'hc8 ##2 sfr_re && !sfr_we && sfr_addr == 8'hc8
		|=> sfr_rdata[5:0] == $past(sfr_wdata[5:0], 3)) else $error("control readback");
	a_irq_holds: assert property (irq_req && !(sfr_we && sfr_addr == 8'hc8)
		&& !$past(sfr_we && sfr_addr == 8'hc8) |=> irq_req)
		else $error("interrupt dropped without clear");
	a_flag_write_irq: assert property (sfr_we && sfr_addr == 8'hc8 && sfr_wdata[7] |-> ##2 irq_req)
		else $error("set flag gave no interrupt");
	a_reset_quiet: assert property ($rose(rst_n) |-> !irq_req && sfr_rdata == 8'h00)
		else $error("outputs not clear after reset");
endmodule
bind timer_reload_counter timer_monitor mon_u (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
	.sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .irq_req(irq_req));
`default_nettype wire

// >>> test/timer_reload_counter_tb.sv
/* Self-checking bench for the reload timer. Assumes source_model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module timer_reload_counter_tb;
	logic ref_clk = 1'b0, rst_n = 1'b0, sfr_we = 1'b0, sfr_re = 1'b0, hi_sel = 1'b0, lo_sel = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v;
	wire [7:0] sfr_rdata;
	wire irq_req, comparator_out, slow_osc_in;
	int fails = 0, n_tests = 0;
	timer_reload_counter dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .high_half_clock_select(hi_sel),
		.low_half_clock_select(lo_sel), .comparator_out(comparator_out), .slow_osc_in(slow_osc_in), .irq_req(irq_req));
	source_model src_u (.ref_clk(ref_clk), .comparator_out(comparator_out), .slow_osc_in(slow_osc_in));
	initial forever #12.5 ref_clk = ~ref_clk;
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bus tasks are entered just after a rising edge.
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfr_we <= 1'b1; sfr_addr <= a; sfr_wdata <= d;
		@(posedge ref_clk) sfr_we <= 1'b0;
		// One idle edge keeps a following write from raising the strobe in the step that lowered it.
		@(posedge ref_clk);
	endtask
	task rd(input logic [7:0] a);
		sfr_re <= 1'b1; sfr_addr <= a;
		@(posedge ref_clk) sfr_re <= 1'b0;
		@(negedge ref_clk) v = sfr_rdata;
		@(posedge ref_clk);
	endtask
	task idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task wait_irq;
		for (int i = 0; i < 400 && irq_req !== 1'b1; i++) @(posedge ref_clk);
		if (irq_req !== 1'b1) begin
			fails++;
			$display("mismatch irq_req expected 1 seen %b", irq_req);
			final_report;
		end
	endtask
	task t_regs;
		rd(8'hca); chk("reload_low reset", 8'h00, v);
		rd(8'hcb); chk("reload_high reset", 8'h00, v);
		rd(8'hcc); chk("count_low reset", 8'h00, v);
		rd(8'h00); chk("unmapped", 8'h00, v);
		wr(8'hca, 8'h5a); rd(8'hca); chk("reload_low", 8'h5a, v);
		wr(8'hcb, 8'ha5); rd(8'hcb); chk("reload_high", 8'ha5, v);
	endtask
	task t_count16;
		wr(8'hcb, 8'hff); wr(8'hca, 8'hf0); wr(8'hcd, 8'hff); wr(8'hcc, 8'hfe);
		lo_sel <= 1'b1;
		wr(8'hc8, 8'h04);
		wait_irq;
		rd(8'hc8); chk("ctrl after wrap", 8'h84, v & 8'hbf);
		wr(8'hc8, 8'h80);
		rd(8'hcd); chk("high after reload", 8'hff, v);
		rd(8'hcc); chk("low after reload", 8'hf0, v & 8'hf0);
		wr(8'hc8, 8'h00); idle(2); chk("irq cleared", 8'h00, {7'h0, irq_req});
	endtask
	task t_split;
		hi_sel <= 1'b1;
		wr(8'hcd, 8'h33); wr(8'hca, 8'hfc); wr(8'hcc, 8'hfc); wr(8'hc8, 8'h08);
		idle(20); chk("irq masked", 8'h00, {7'h0, irq_req});
		rd(8'hc8); chk("low flag split", 8'h48, v);
		wr(8'hc8, 8'h68); idle(2); chk("irq low enabled", 8'h01, {7'h0, irq_req});
		wr(8'hc8, 8'h60);
		rd(8'hcd); chk("high gated", 8'h33, v);
		rd(8'hcc); chk("low reloaded", 8'hf0, v & 8'hf0);
		wr(8'hc8, 8'h00); idle(2); chk("irq low cleared", 8'h00, {7'h0, irq_req});
	endtask
	task t_comp;
		lo_sel <= 1'b0;
		wr(8'hcc, 8'h00); wr(8'hcd, 8'h00); wr(8'hc8, 8'h05);
		src_u.pulse(3); idle(8);
		rd(8'hcc); chk("comparator count", 8'h03, v);
		wr(8'hc8, 8'h00);
	endtask
	task t_capture;
		lo_sel <= 1'b1;
		wr(8'hca, 8'h00); wr(8'hcb, 8'h00); wr(8'hc8, 8'h16);
		src_u.pulse(1);
		wait_irq;
		rd(8'hcb); chk("captured high", 8'h00, v);
		rd(8'hca); chk("captured low", 8'h01, {7'h0, v != 8'h00});
		wr(8'hc8, 8'h00);
	endtask
	initial begin
		idle(4);
		rst_n <= 1'b1;
		t_regs;
		t_count16;
		t_split;
		t_comp;
		t_capture;
		final_report;
	end
endmodule
`default_nettype wire
